//--- record_bank.sv
// record storage: one flip-flop word per record slot, one write and one read port
`timescale 1ns/1ns
`default_nettype none
module record_bank (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire record_update_pkg::wr_t wr_i,
   input wire record_update_pkg::slot_idx_t rd_idx_i,
   output logic [record_update_pkg::REC_W-1:0] rd_data_o
);

   typedef struct packed {
      record_update_pkg::rec_t [record_update_pkg::SLOTS-1:0] mem;
   } bank_t;

   bank_t s_q;
   bank_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (wr_i.en)
      begin
         s_d.mem[wr_i.idx] = wr_i.data;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         s_q <= '{mem: {record_update_pkg::SLOTS{record_update_pkg::REC_RESET}}};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign rd_data_o = s_q.mem[rd_idx_i];

endmodule
`default_nettype wire

//--- record_update_command_logic.sv
// record update command engine with record pointer, cyclic rotation and status words
`timescale 1ns/1ns
`default_nettype none
module record_update_command_logic (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic cmd_valid_i,
   input wire record_update_pkg::cmd_t cmd_i,
   input wire logic select_valid_i,
   input wire record_update_pkg::file_idx_t select_file_i,
   input wire logic [record_update_pkg::NUM_FILES-1:0] update_allowed_i,
   input wire logic rd_valid_i,
   input wire record_update_pkg::file_idx_t rd_file_i,
   input wire logic [7:0] rd_rec_i,
   output logic ready_o,
   output logic done_o,
   output record_update_pkg::status_t status_o,
   output logic file_valid_o,
   output record_update_pkg::file_idx_t cur_file_o,
   output logic ptr_set_o,
   output logic [7:0] rec_ptr_o,
   output logic rd_done_o,
   output logic rd_ok_o,
   output logic [record_update_pkg::REC_W-1:0] rd_data_o
);

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_EXEC = 2'h1
   } state_t;

   typedef struct packed {
      state_t st;
      logic ready;
      logic done;
      record_update_pkg::status_t sw;
      record_update_pkg::cmd_t cmd;
      logic cur_valid;
      record_update_pkg::file_idx_t cur;
      logic ptr_set;
      logic [7:0] ptr;
      logic [record_update_pkg::NUM_FILES-1:0][record_update_pkg::PHYS_W-1:0] head;
      logic rd_done;
      logic rd_ok;
      record_update_pkg::rec_t rd_data;
   } core_t;

   localparam core_t CORE_RESET = '{
      st: ST_IDLE,
      ready: 1'b0,
      done: 1'b0,
      sw: record_update_pkg::SW_IDLE,
      cmd: '0,
      cur_valid: 1'b0,
      cur: '0,
      ptr_set: 1'b0,
      ptr: 8'h00,
      head: '0,
      rd_done: 1'b0,
      rd_ok: 1'b0,
      rd_data: '0
   };

   core_t s_q;
   core_t s_d;
   record_update_pkg::wr_t wr;
   record_update_pkg::slot_idx_t rd_idx;
   record_update_pkg::rec_t bank_rd_data;

   // working values of the command evaluation
   record_update_pkg::file_idx_t f;
   logic fvalid;
   logic set_w;
   logic [7:0] ptr_w;
   logic [7:0] n;
   logic cyc;
   logic ok;
   logic [7:0] tgt;
   logic [7:0] new_ptr;
   logic rotate;
   record_update_pkg::phys_idx_t oldest;
   record_update_pkg::slot_idx_t old_slot;
   record_update_pkg::status_t err;
   logic [7:0] rd_n;

   record_bank u_bank (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .wr_i(wr),
      .rd_idx_i(rd_idx),
      .rd_data_o(bank_rd_data)
   );

   always_comb
   begin
      s_d = s_q;
      wr = '0;
      f = s_q.cur;
      fvalid = s_q.cur_valid;
      set_w = s_q.ptr_set;
      ptr_w = s_q.ptr;
      n = 8'h00;
      cyc = 1'b0;
      ok = 1'b0;
      tgt = 8'h00;
      new_ptr = s_q.ptr;
      rotate = 1'b0;
      oldest = '0;
      old_slot = '0;
      err = record_update_pkg::SW_OK;
      s_d.done = 1'b0;
      s_d.rd_done = 1'b0;

      // read port for checking stored contents, one cycle latency
      rd_n = record_update_pkg::file_recs(rd_file_i);
      rd_idx = record_update_pkg::slot_of(rd_file_i, s_q.head[rd_file_i], rd_rec_i);
      if (rd_valid_i)
      begin
         s_d.rd_done = 1'b1;
         s_d.rd_ok = (rd_rec_i >= record_update_pkg::REC_ONE) && (rd_rec_i <= rd_n);
         s_d.rd_data = s_d.rd_ok ? bank_rd_data : '0;
      end

      case (s_q.st)
         ST_IDLE:
         begin
            s_d.ready = 1'b1;
            if (cmd_valid_i)
            begin
               s_d.cmd = cmd_i; // R2
               s_d.ready = 1'b0;
               s_d.st = ST_EXEC;
            end
            else if (select_valid_i)
            begin
               s_d.cur = select_file_i;
               s_d.cur_valid = 1'b1;
               s_d.ptr_set = 1'b0; // R19
               s_d.ptr = 8'h00;
            end
         end
         ST_EXEC:
         begin
            // short file identifier selection happens before anything else
            if (s_q.cmd.sfi_valid)
            begin
               if ((s_q.cmd.short_file_identifier != record_update_pkg::SFI_NONE) &&
                   (s_q.cmd.short_file_identifier <= record_update_pkg::SFI_LAST))
               begin
                  f = record_update_pkg::FILE_W'(s_q.cmd.short_file_identifier - 5'h01); // R16
                  fvalid = 1'b1;
                  set_w = 1'b0; // R16
                  ptr_w = 8'h00;
               end
               else
               begin
                  err = record_update_pkg::SW_FILE_NOT_FOUND;
               end
            end
            new_ptr = ptr_w;
            n = record_update_pkg::file_recs(f);
            cyc = record_update_pkg::FILE_CYCLIC[f];
            old_slot = record_update_pkg::slot_of(f, s_q.head[f], n);
            oldest = old_slot[record_update_pkg::PHYS_W-1:0];

            if (err != record_update_pkg::SW_OK)
            begin
               ok = 1'b0;
            end
            else if (!fvalid)
            begin
               err = record_update_pkg::SW_NO_FILE;
            end
            else if (!update_allowed_i[f])
            begin
               err = record_update_pkg::SW_SECURITY; // R3
            end
            else if (cyc && (s_q.cmd.mode != record_update_pkg::MODE_PREVIOUS))
            begin
               err = record_update_pkg::SW_STRUCTURE; // R4
            end
            else if (s_q.cmd.length != record_update_pkg::REC_LEN_B)
            begin
               err = record_update_pkg::SW_WRONG_LENGTH;
            end
            else
            begin
               case (s_q.cmd.mode)
                  record_update_pkg::MODE_CURRENT:
                  begin
                     if (set_w)
                     begin
                        tgt = ptr_w; // R5
                        ok = 1'b1;
                     end
                     else
                     begin
                        err = record_update_pkg::SW_NOT_FOUND;
                     end
                  end
                  record_update_pkg::MODE_ABSOLUTE:
                  begin
                     if ((s_q.cmd.rec_num >= record_update_pkg::REC_ONE) &&
                         (s_q.cmd.rec_num <= n))
                     begin
                        tgt = s_q.cmd.rec_num; // R6
                        ok = 1'b1;
                     end
                     else
                     begin
                        err = record_update_pkg::SW_NOT_FOUND; // R18
                     end
                  end
                  record_update_pkg::MODE_NEXT:
                  begin
                     // the record number byte is not looked at here
                     if (!set_w)
                     begin
                        tgt = record_update_pkg::REC_ONE; // R8
                        new_ptr = record_update_pkg::REC_ONE;
                        ok = 1'b1;
                     end
                     else if (ptr_w == n)
                     begin
                        err = record_update_pkg::SW_NOT_FOUND; // R9
                     end
                     else
                     begin
                        tgt = 8'(ptr_w + record_update_pkg::REC_ONE); // R7
                        new_ptr = tgt;
                        ok = 1'b1;
                     end
                  end
                  record_update_pkg::MODE_PREVIOUS:
                  begin
                     if (cyc)
                     begin
                        tgt = n; // R13
                        rotate = 1'b1;
                        new_ptr = record_update_pkg::REC_ONE;
                        ok = 1'b1;
                     end
                     else if (!set_w)
                     begin
                        tgt = n; // R11
                        new_ptr = n;
                        ok = 1'b1;
                     end
                     else if (ptr_w == record_update_pkg::REC_ONE)
                     begin
                        err = record_update_pkg::SW_NOT_FOUND; // R12
                     end
                     else
                     begin
                        tgt = 8'(ptr_w - record_update_pkg::REC_ONE); // R10
                        new_ptr = tgt;
                        ok = 1'b1;
                     end
                  end
                  default:
                  begin
                     err = record_update_pkg::SW_NOT_FOUND;
                  end
               endcase
            end

            // file selection by short identifier persists even on failure
            s_d.cur = f;
            s_d.cur_valid = fvalid;
            s_d.ptr_set = set_w; // R14
            s_d.ptr = ptr_w; // R14
            if (ok)
            begin
               wr.en = 1'b1; // R1
               wr.idx = record_update_pkg::slot_of(f, s_q.head[f], tgt);
               wr.data = s_q.cmd.data; // R1
               // only the stepping modes move the pointer; current and absolute keep it
               if ((s_q.cmd.mode == record_update_pkg::MODE_NEXT) ||
                   (s_q.cmd.mode == record_update_pkg::MODE_PREVIOUS))
               begin
                  s_d.ptr_set = 1'b1; // R7, R10
                  s_d.ptr = new_ptr;
               end
               if (rotate)
               begin
                  s_d.head[f] = oldest; // R13
               end
               s_d.sw = record_update_pkg::SW_OK; // R17
            end
            else
            begin
               s_d.sw = err;
            end
            s_d.done = 1'b1;
            s_d.ready = 1'b1;
            s_d.st = ST_IDLE;
         end
         default:
         begin
            s_d.st = ST_IDLE;
            s_d.ready = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         s_q <= CORE_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign ready_o = s_q.ready;
   assign done_o = s_q.done;
   assign status_o = s_q.sw;
   assign file_valid_o = s_q.cur_valid;
   assign cur_file_o = s_q.cur;
   assign ptr_set_o = s_q.ptr_set;
   assign rec_ptr_o = s_q.ptr;
   assign rd_done_o = s_q.rd_done;
   assign rd_ok_o = s_q.rd_ok;
   assign rd_data_o = s_q.rd_data;

endmodule
`default_nettype wire

//--- record_update_command_logic_sva.sv
// concurrent checks on the record update command logic ports
`timescale 1ns/1ns
`default_nettype none
module record_update_command_logic_sva (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic cmd_valid_i,
   input wire record_update_pkg::cmd_t cmd_i,
   input wire logic select_valid_i,
   input wire record_update_pkg::file_idx_t select_file_i,
   input wire logic [record_update_pkg::NUM_FILES-1:0] update_allowed_i,
   input wire logic ready_o,
   input wire logic done_o,
   input wire record_update_pkg::status_t status_o,
   input wire logic file_valid_o,
   input wire record_update_pkg::file_idx_t cur_file_o,
   input wire logic ptr_set_o,
   input wire logic [7:0] rec_ptr_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   wire logic take = ready_o && cmd_valid_i;
   wire logic plain = take && !cmd_i.sfi_valid && file_valid_o;
   wire logic ok = plain && update_allowed_i[cur_file_o];
   wire logic cyc = record_update_pkg::FILE_CYCLIC[cur_file_o];
   sequence s_exec;
      !ready_o ##1 (done_o && ready_o);
   endsequence
   sequence s_keep;
      ##2 (rec_ptr_o == $past(rec_ptr_o, 2) && ptr_set_o == $past(ptr_set_o, 2));
   endsequence
   property p_answer;
      take |=> s_exec;
   endproperty
   a_answer: assert property (p_answer) else $error("answer timing wrong");
   property p_security;
      plain && !update_allowed_i[cur_file_o] |=> ##1 status_o == record_update_pkg::SW_SECURITY;
   endproperty
   a_security: assert property (p_security) else $error("access not refused");
   property p_cyclic;
      ok && cyc && cmd_i.mode != 2'h3 |=> ##1 status_o == record_update_pkg::SW_STRUCTURE;
   endproperty
   a_cyclic: assert property (p_cyclic) else $error("cyclic mode not refused");
   property p_cur_keep;
      plain && cmd_i.mode == 2'h0 |-> s_keep;
   endproperty
   a_cur_keep: assert property (p_cur_keep) else $error("current moved pointer");
   property p_abs_keep;
      plain && cmd_i.mode == 2'h1 |-> s_keep;
   endproperty
   a_abs_keep: assert property (p_abs_keep) else $error("absolute moved pointer");
   property p_next_first;
      ok && !cyc && cmd_i.mode == 2'h2 && !ptr_set_o && cmd_i.length == 8'h04
         |=> ##1 ptr_set_o && rec_ptr_o == 8'h01;
   endproperty
   a_next_first: assert property (p_next_first) else $error("first next wrong");
   property p_fail_keep;
      plain |=> ##1 (status_o == record_update_pkg::SW_OK || rec_ptr_o == $past(rec_ptr_o, 2));
   endproperty
   a_fail_keep: assert property (p_fail_keep) else $error("failure moved pointer");
   property p_sfi;
      take && cmd_i.sfi_valid && cmd_i.short_file_identifier inside {[5'h01:5'h04]}
         |=> ##1 file_valid_o && cur_file_o == 2'($past(cmd_i.short_file_identifier, 2) - 5'h01);
   endproperty
   a_sfi: assert property (p_sfi) else $error("short id not selected");
   property p_select;
      select_valid_i && ready_o && !cmd_valid_i
         |=> file_valid_o && !ptr_set_o && rec_ptr_o == 8'h00 && cur_file_o == $past(select_file_i);
   endproperty
   a_select: assert property (p_select) else $error("select left pointer");
endmodule
bind record_update_command_logic record_update_command_logic_sva u_record_update_command_logic_sva (
   .clk_i, .reset_i, .cmd_valid_i, .cmd_i, .select_valid_i, .select_file_i, .update_allowed_i,
   .ready_o, .done_o, .status_o, .file_valid_o, .cur_file_o, .ptr_set_o, .rec_ptr_o);
`default_nettype wire

//--- record_update_pkg.sv
// shared constants, types and helpers for the record update command logic
// Overview of operation
// R1: update overwrites one complete record
// R2: command carries mode, number, length, data
// R3: refuse with 6982 unless access satisfied
// R4: cyclic files accept previous mode only
// R5: current mode writes pointed record
// R6: absolute mode writes numbered record, pointer kept
// R7: next mode advances pointer, then writes
// R8: next without pointer writes record one
// R9: next at last record writes nothing
// R10: previous mode steps pointer back, then writes
// R11: previous without pointer writes last record
// R12: linear previous at record one writes nothing
// R13: cyclic previous overwrites oldest, renumbers it first
// R14: failed command leaves pointer untouched; the code clears it when the command carried a valid short id
// R15: terminal zeroes parameter byte for next/previous
// R16: valid short id selects file, clears pointer
// R17: success answers 90 00
// R18: absolute beyond last record answers 6a 83
// R19: file selection leaves pointer unset
package record_update_pkg;

   localparam int NUM_FILES = 4;
   localparam int FILE_W = 2;
   localparam int MAX_RECS = 4;
   localparam int PHYS_W = 2;
   localparam int SLOTS = NUM_FILES * MAX_RECS;
   localparam int SLOT_W = FILE_W + PHYS_W;
   localparam int REC_LEN = 4;
   localparam int REC_W = REC_LEN * 8;

   localparam logic [7:0] REC_LEN_B = 8'h04;
   localparam logic [7:0] REC_ONE = 8'h01;
   localparam logic [4:0] SFI_NONE = 5'h00;
   localparam logic [4:0] SFI_LAST = 5'h04;
   localparam logic [REC_W-1:0] REC_RESET = 32'hffffffff;

   // file 1 is cyclic, the others linear fixed
   localparam logic [NUM_FILES-1:0] FILE_CYCLIC = 4'h2;

   typedef logic [FILE_W-1:0] file_idx_t;
   typedef logic [PHYS_W-1:0] phys_idx_t;
   typedef logic [SLOT_W-1:0] slot_idx_t;
   typedef logic [REC_W-1:0] rec_t;

   typedef enum logic [1:0] {
      MODE_CURRENT = 2'h0,
      MODE_ABSOLUTE = 2'h1,
      MODE_NEXT = 2'h2,
      MODE_PREVIOUS = 2'h3
   } mode_t;

   typedef struct packed {
      logic [7:0] sw1;
      logic [7:0] sw2;
   } status_t;

   localparam status_t SW_OK = '{sw1: 8'h90, sw2: 8'h00};
   localparam status_t SW_SECURITY = '{sw1: 8'h69, sw2: 8'h82};
   localparam status_t SW_NOT_FOUND = '{sw1: 8'h6a, sw2: 8'h83};
   localparam status_t SW_STRUCTURE = '{sw1: 8'h69, sw2: 8'h81};
   localparam status_t SW_NO_FILE = '{sw1: 8'h69, sw2: 8'h86};
   localparam status_t SW_FILE_NOT_FOUND = '{sw1: 8'h6a, sw2: 8'h82};
   localparam status_t SW_WRONG_LENGTH = '{sw1: 8'h67, sw2: 8'h00};
   localparam status_t SW_IDLE = '{sw1: 8'h00, sw2: 8'h00};

   typedef struct packed {
      mode_t mode;
      logic [7:0] rec_num;
      logic [7:0] length;
      logic sfi_valid;
      logic [4:0] short_file_identifier;
      rec_t data;
   } cmd_t;

   typedef struct packed {
      logic en;
      slot_idx_t idx;
      rec_t data;
   } wr_t;

   // number of records held by each file
   function automatic logic [7:0] file_recs(input file_idx_t f);
      logic [7:0] n;
      case (f)
         2'h0: n = 8'h04;
         2'h1: n = 8'h04;
         2'h2: n = 8'h03;
         default: n = 8'h02;
      endcase
      return n;
   endfunction

   // logical record number (1-based) to storage slot, rotated by head for cyclic files
   function automatic slot_idx_t slot_of(input file_idx_t f, input phys_idx_t head,
                                          input logic [7:0] rec);
      logic [7:0] s;
      logic [7:0] n;
      n = file_recs(f);
      s = 8'(rec - REC_ONE);
      if (FILE_CYCLIC[f])
      begin
         s = 8'(s + 8'(head));
         if (s >= n)
         begin
            s = 8'(s - n);
         end
      end
      return {f, s[PHYS_W-1:0]};
   endfunction

endpackage

//--- terminal_model.sv
// terminal side model: drives update, select and read-back requests
`timescale 1ns/1ns
`default_nettype none
module terminal_model (
   input wire logic clk_i,
   input wire logic ready_i,
   input wire logic done_i,
   output logic cmd_valid_o,
   output record_update_pkg::cmd_t cmd_o,
   output logic select_valid_o,
   output record_update_pkg::file_idx_t select_file_o,
   output logic rd_valid_o,
   output record_update_pkg::file_idx_t rd_file_o,
   output logic [7:0] rd_rec_o
);
   int gap = 0;
   logic [7:0] len = 8'h04;
   initial
   begin
      cmd_valid_o = 1'b0;
      cmd_o = '0;
      select_valid_o = 1'b0;
      select_file_o = 2'h0;
      rd_valid_o = 1'b0;
      rd_file_o = 2'h0;
      rd_rec_o = 8'h00;
   end
   // hold the request until an edge sees ready
   task automatic hold;
      do @(posedge clk_i); while (!ready_i);
   endtask
   task automatic issue(input logic [1:0] m, input logic [7:0] n, input logic [4:0] s,
                        input logic [31:0] d);
      int k;
      repeat (gap + 1) @(posedge clk_i);
      cmd_o <= '{mode: record_update_pkg::mode_t'(m), rec_num: (m[1] ? 8'h00 : n),
                 length: len, sfi_valid: (s != 5'h00), short_file_identifier: s, data: d};
      cmd_valid_o <= 1'b1;
      hold();
      cmd_valid_o <= 1'b0;
      cmd_o <= record_update_pkg::cmd_t'(~cmd_o);
      k = 0;
      while (done_i !== 1'b1 && k < 8)
      begin
         @(posedge clk_i);
         k++;
      end
   endtask
   task automatic pick(input logic [1:0] f);
      @(posedge clk_i);
      select_file_o <= f;
      select_valid_o <= 1'b1;
      hold();
      select_valid_o <= 1'b0;
      select_file_o <= ~f;
      @(posedge clk_i);
   endtask
   task automatic fetch(input logic [1:0] f, input logic [7:0] n);
      @(posedge clk_i);
      rd_file_o <= f;
      rd_rec_o <= n;
      rd_valid_o <= 1'b1;
      @(posedge clk_i);
      rd_valid_o <= 1'b0;
      rd_file_o <= ~f;
      rd_rec_o <= ~n;
      @(posedge clk_i);
   endtask
endmodule
`default_nettype wire

//--- test_record_update_command_logic.sv
// self-checking bench for the record update command logic
`timescale 1ns/1ns
`default_nettype none
module test_record_update_command_logic;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [3:0] allow = 4'he;
   logic cmd_valid, sel_valid, rd_valid, ready, done, fvalid, pset, rd_done, rd_ok;
   record_update_pkg::cmd_t cmd;
   record_update_pkg::file_idx_t sel_file, rd_file, cur_file;
   record_update_pkg::status_t status;
   logic [7:0] rd_rec, ptr;
   logic [31:0] rd_data;
   int errors = 0;
   int cmp_count = 0;
   always #25 clk_i = ~clk_i;
   record_update_command_logic u_record_update_command_logic (.clk_i(clk_i), .reset_i(reset_i),
      .cmd_valid_i(cmd_valid), .cmd_i(cmd), .select_valid_i(sel_valid),
      .select_file_i(sel_file), .update_allowed_i(allow), .rd_valid_i(rd_valid),
      .rd_file_i(rd_file), .rd_rec_i(rd_rec), .ready_o(ready), .done_o(done),
      .status_o(status), .file_valid_o(fvalid), .cur_file_o(cur_file), .ptr_set_o(pset),
      .rec_ptr_o(ptr), .rd_done_o(rd_done), .rd_ok_o(rd_ok), .rd_data_o(rd_data));
   terminal_model u_terminal_model (.clk_i(clk_i), .ready_i(ready), .done_i(done),
      .cmd_valid_o(cmd_valid), .cmd_o(cmd), .select_valid_o(sel_valid),
      .select_file_o(sel_file), .rd_valid_o(rd_valid), .rd_file_o(rd_file), .rd_rec_o(rd_rec));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic up(input logic [1:0] m, input logic [7:0] n, input logic [4:0] s,
                     input logic [31:0] d, input logic [15:0] sw);
      u_terminal_model.issue(m, n, s, d);
      chk(32'(status), 32'(sw));
   endtask
   task automatic pt(input logic s, input logic [7:0] p);
      chk(32'({pset, ptr}), 32'({s, p}));
   endtask
   task automatic rd(input logic [1:0] f, input logic [7:0] n, input logic [31:0] d);
      u_terminal_model.fetch(f, n);
      chk(rd_data, d);
      chk(32'({rd_done, rd_ok}), 32'h3);
   endtask
   task automatic t_access;
      u_terminal_model.pick(2'h0);
      up(2'h1, 8'h01, 5'h00, 32'hc1c1c1c1, 16'h6982);
      allow <= 4'hf;
      up(2'h1, 8'h01, 5'h00, 32'hc2c2c2c2, 16'h9000);
      rd(2'h0, 8'h01, 32'hc2c2c2c2);
      chk(32'({pset, ptr}), 32'h0);
   endtask
   task automatic t_linear;
      u_terminal_model.pick(2'h0);
      chk(32'({pset, ptr}), 32'h0);
      up(2'h2, 8'h00, 5'h00, 32'hf1f1f1f1, 16'h9000);
      chk(32'({pset, ptr}), 32'h101);
      up(2'h1, 8'h02, 5'h00, 32'hc3c3c3c3, 16'h9000);
      chk(32'({pset, ptr}), 32'h101);
      up(2'h0, 8'h00, 5'h00, 32'hc4c4c4c4, 16'h9000);
      rd(2'h0, 8'h01, 32'hc4c4c4c4);
      up(2'h2, 8'h00, 5'h00, 32'hc5c5c5c5, 16'h9000);
      chk(32'({pset, ptr}), 32'h102);
      rd(2'h0, 8'h02, 32'hc5c5c5c5);
      up(2'h1, 8'h05, 5'h00, 32'hc7c7c7c7, 16'h6a83);
      chk(32'({pset, ptr}), 32'h102);
   endtask
   task automatic t_prev;
      u_terminal_model.gap = 2;
      u_terminal_model.pick(2'h2);
      up(2'h3, 8'h00, 5'h00, 32'hc6c6c6c6, 16'h9000);
      chk(32'({pset, ptr}), 32'h103);
      rd(2'h2, 8'h03, 32'hc6c6c6c6);
      up(2'h2, 8'h00, 5'h00, 32'hc7c7c7c7, 16'h6a83);
      chk(32'({pset, ptr}), 32'h103);
      rd(2'h2, 8'h03, 32'hc6c6c6c6);
      up(2'h3, 8'h00, 5'h00, 32'hc9c9c9c9, 16'h9000);
      chk(32'({pset, ptr}), 32'h102);
      u_terminal_model.gap = 0;
      u_terminal_model.pick(2'h2);
      up(2'h2, 8'h00, 5'h00, 32'hcacacaca, 16'h9000);
      up(2'h3, 8'h00, 5'h00, 32'hcbcbcbcb, 16'h6a83);
      chk(32'({pset, ptr}), 32'h101);
      rd(2'h2, 8'h01, 32'hcacacaca);
   endtask
   task automatic t_cyclic;
      int m;
      u_terminal_model.pick(2'h1);
      for (m = 0; m < 3; m++)
      begin
         up(2'(m), 8'h01, 5'h00, 32'hc9c9c9c9, 16'h6981);
      end
      chk(32'({pset, ptr}), 32'h0);
      up(2'h3, 8'h00, 5'h00, 32'hcccccccc, 16'h9000);
      up(2'h3, 8'h00, 5'h00, 32'hcdcdcdcd, 16'h9000);
      chk(32'({pset, ptr}), 32'h101);
      rd(2'h1, 8'h01, 32'hcdcdcdcd);
      rd(2'h1, 8'h02, 32'hcccccccc);
      rd(2'h1, 8'h03, 32'hffffffff);
   endtask
   task automatic t_sfi;
      u_terminal_model.pick(2'h0);
      up(2'h2, 8'h00, 5'h00, 32'hf2f2f2f2, 16'h9000);
      up(2'h1, 8'h01, 5'h03, 32'hc0c0c0c0, 16'h9000);
      chk(32'({fvalid, cur_file, pset}), 32'hc);
      rd(2'h2, 8'h01, 32'hc0c0c0c0);
      up(2'h2, 8'h00, 5'h00, 32'hc8c8c8c8, 16'h9000);
      chk(32'({pset, ptr}), 32'h101);
      rd(2'h2, 8'h01, 32'hc8c8c8c8);
   endtask
   task automatic t_errors;
      u_terminal_model.len = 8'h03;
      up(2'h1, 8'h01, 5'h00, 32'hd0d0d0d0, 16'h6700);
      u_terminal_model.len = 8'h04;
      up(2'h1, 8'h01, 5'h07, 32'hd1d1d1d1, 16'h6a82);
      chk(32'({fvalid, cur_file}), 32'h6);
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      chk(32'({ready, done, fvalid, pset, status}), 32'h0);
      up(2'h2, 8'h00, 5'h00, 32'hd2d2d2d2, 16'h6986);
      chk(32'(fvalid), 32'h0);
      pt(1'b0, 8'h00);
      rd(2'h1, 8'h01, 32'hffffffff);
      u_terminal_model.fetch(2'h3, 8'h03);
      chk(32'({rd_done, rd_ok}), 32'h2);
      chk(rd_data, 32'h0);
   endtask
   task automatic complete_run;
      if (errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      #100000;
      errors++;
      complete_run();
   end
   initial
   begin
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      t_access();
      t_linear();
      t_prev();
      t_cyclic();
      t_sfi();
      t_errors();
      complete_run();
   end
endmodule
`default_nettype wire
